// [common/ceq_pkg.sv]
// Notes on behaviour
// - register access only while mode select high
// - four eight-bit registers, seven-bit address
// - write: zero, seven address, eight data bits
// - master holds select low per frame
// - device samples data on clock rising edge
// - data output released throughout write frame
// - read header: one, then seven address bits
// - fetch at eighth rise, shift out from fall
// - master releases data line after eighth rise
// - swing field, reset 011
// - common mode field, reset 001
// - coarse launch bit, reset 0
// - fine launch gain field
// - read-only five-bit cable length code
// - extended reach enable bit
// - carrier status bit reads detector
// - extended reach off after reset
// - stay normal without carrier or long cable
// - carrier and short cable allow extended
// - enter: force sleep, set bit, wait, restore
// - leave: force sleep, clear bit, wait, restore
// - sleep field codes, reset 01
// - reserved general bits written as zero
package ceq_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int FRAME_BITS = 16;
	localparam int HDR_BITS = 8;
	// register addresses on the serial link
	localparam logic [6:0] REG_GEN = 7'h00;
	localparam logic [6:0] REG_DRV = 7'h01;
	localparam logic [6:0] REG_LAUNCH = 7'h02;
	localparam logic [6:0] REG_LEN = 7'h03;
	// field positions
	localparam int GEN_CD_BIT = 7;
	localparam int GEN_MUTE_BIT = 6;
	localparam int GEN_BYP_BIT = 5;
	localparam int GEN_SLEEP_LSB = 3;
	localparam int GEN_EXT_BIT = 2;
	localparam int DRV_SWING_LSB = 5;
	localparam int DRV_CM_LSB = 2;
	localparam int LA_COARSE_BIT = 7;
	localparam int LA_FINE_LSB = 3;
	localparam int LEN_LSB = 3;
	// values after reset
	localparam logic [1:0] SLEEP_RST = 2'h1;
	localparam logic EXT_RST = 1'b0;
	localparam logic MUTE_RST = 1'b0;
	localparam logic BYP_RST = 1'b0;
	localparam logic [2:0] SWING_RST = 3'h3;
	localparam logic [2:0] CM_RST = 3'h1;
	localparam logic COARSE_RST = 1'b0;
	localparam logic [3:0] FINE_RST = 4'h0;
	// sleep codes
	localparam logic [1:0] SLEEP_NEVER = 2'h0;
	localparam logic [1:0] SLEEP_AUTO = 2'h1;
	localparam logic [1:0] SLEEP_FORCE = 2'h2;
	// controller registers on the system bus
	localparam logic [7:0] HOST_CMD_OFS = 8'h00;
	localparam logic [7:0] HOST_STAT_OFS = 8'h04;
	localparam logic [7:0] HOST_SEQ_OFS = 8'h08;
	localparam int CMD_RD_BIT = 16;
	localparam int SEQ_THR_LSB = 8;
	localparam logic [4:0] THR_RST = 5'h12;
	localparam logic [1:0] RESTORE_RST = 2'h1;
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCK_PERIOD_NS = 400;
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int EXT_WAIT_US = 1000;
	localparam int EXT_WAIT_CYC =
		(EXT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// serial engine of the controller
	typedef enum logic [2:0] {
		E_IDLE = 3'b000,
		E_LOW = 3'b001,
		E_HIGH = 3'b010,
		E_END = 3'b011,
		E_GAP = 3'b100
	} ceq_eng_t;
	// reach sequencer of the controller
	typedef enum logic [2:0] {
		Q_OFF = 3'b000,
		Q_RD_CD = 3'b001,
		Q_RD_LEN = 3'b010,
		Q_SLEEP = 3'b011,
		Q_SET_EXT = 3'b100,
		Q_WAIT = 3'b101,
		Q_RESTORE = 3'b110,
		Q_EXT_POLL = 3'b111
	} ceq_seq_t;
endpackage : ceq_pkg

// [common/ceq_spi_if.sv]
`timescale 1ns/10ps
// serial link; an enable high marks a released line, which the receiving end still shifts in
interface ceq_spi_if;
	logic sck;
	logic ss_n;
	logic mosi;
	logic mosi_oe_n;
	logic miso;
	logic miso_oe_n;
	modport dev (
		input sck,
		input ss_n,
		input mosi,
		output miso,
		output miso_oe_n
	);
	modport host (
		output sck,
		output ss_n,
		output mosi,
		output mosi_oe_n,
		input miso
	);
endinterface : ceq_spi_if

// [verilog/ceq_sync.sv]
`timescale 1ns/10ps
// two-stage synchroniser; only the second stage is visible
module ceq_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds the second and nothing else
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
		end
		else if (ce)
		begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule : ceq_sync

// [verilog/ceq_device.sv]
`timescale 1ns/10ps
// register end of the equaliser: samples the serial link on core_clk
module ceq_device (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic spi_en,
	input wire logic carrier_detect,
	input wire logic [4:0] cable_length_code,
	ceq_spi_if.dev spi,
	output logic mute,
	output logic bypass,
	output logic [1:0] sleep_mode,
	output logic ext_reach,
	output logic [2:0] output_differential_swing,
	output logic [2:0] output_common_mode_level,
	output logic launch_coarse,
	output logic [3:0] launch_fine
);
	////////////////////////////////////////////////////////////////////////
	// one-hot register select, shared by the read and write paths
	function automatic logic [3:0] sel_reg(input logic [6:0] a);
		sel_reg = {a == ceq_pkg::REG_LEN, a == ceq_pkg::REG_LAUNCH,
			a == ceq_pkg::REG_DRV, a == ceq_pkg::REG_GEN};
	endfunction : sel_reg

	logic [9:0] raw;
	logic [9:0] syn;
	logic en_s;
	logic ss_n_s;
	logic sck_s;
	logic mosi_s;
	logic cd_s;
	logic [4:0] len_s;
	logic sck_prev_q;
	logic rise;
	logic fall;
	logic frame_on;
	logic [4:0] bit_cnt_q;
	logic [15:0] sh_q;
	logic [15:0] sh_d;
	logic rd_q;
	logic [7:0] tx_q;
	logic miso_q;
	logic miso_oe_n_q;
	logic hdr_done;
	logic frame_done;
	logic rd_cmd;
	logic wr_en;
	logic [3:0] rsel;
	logic [3:0] wsel;
	logic [7:0] wdat;
	logic [7:0] rd_gen;
	logic [7:0] rd_drv;
	logic [7:0] rd_launch;
	logic [7:0] rd_len;
	logic [7:0] rd_word;
	logic mute_q;
	logic bypass_q;
	logic [1:0] sleep_q;
	logic ext_q;
	logic [2:0] swing_q;
	logic [2:0] cm_q;
	logic coarse_q;
	logic [3:0] fine_q;

	////////////////////////////////////////////////////////////////////////
	// every pin and the analog status pass two flops first; the length
	// code moves slowly, so a torn sample only costs one stale read
	assign raw = {spi_en, spi.ss_n, spi.sck, spi.mosi, carrier_detect,
		cable_length_code};

	ceq_sync #(
		.W(10),
		.INIT(10'h100)
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.ce(ce),
		.d(raw),
		.q(syn)
	);

	assign en_s = syn[9];
	assign ss_n_s = syn[8];
	assign sck_s = syn[7];
	assign mosi_s = syn[6];
	assign cd_s = syn[5];
	assign len_s = syn[4:0];

	////////////////////////////////////////////////////////////////////////
	// edge detection on the synchronised serial clock
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			sck_prev_q <= 1'b0;
		else if (ce)
			sck_prev_q <= sck_s;
	end

	assign rise = sck_s & ~sck_prev_q;
	assign fall = ~sck_s & sck_prev_q;
	// pin mode blocks every frame
	assign frame_on = en_s & ~ss_n_s;

	////////////////////////////////////////////////////////////////////////
	// frame decode; shifting in at the low end keeps msb first
	assign sh_d = {sh_q[14:0], mosi_s};
	assign hdr_done = rise & frame_on &
		(bit_cnt_q == 5'(ceq_pkg::HDR_BITS - 1));
	assign frame_done = rise & frame_on &
		(bit_cnt_q == 5'(ceq_pkg::FRAME_BITS - 1));
	assign rd_cmd = sh_d[ceq_pkg::HDR_BITS - 1];
	// write frame: command zero, address, data in that order
	assign wr_en = frame_done & ~sh_d[ceq_pkg::FRAME_BITS - 1] & ~rd_q;
	assign wdat = sh_d[ceq_pkg::DATA_W - 1:0];
	assign wsel = sel_reg(sh_d[14:8]);
	assign rsel = sel_reg(sh_d[6:0]);

	////////////////////////////////////////////////////////////////////////
	// read view of the registers; reserved bits read as zero
	assign rd_gen = {cd_s, mute_q, bypass_q, sleep_q, ext_q, 2'h0};
	assign rd_drv = {swing_q, cm_q, 2'h0};
	assign rd_launch = {coarse_q, fine_q, 3'h0};
	assign rd_len = {len_s, 3'h0};
	assign rd_word = rsel[0] ? rd_gen :
		rsel[1] ? rd_drv :
		rsel[2] ? rd_launch :
		rsel[3] ? rd_len : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// bit counter and receive shifter; counting stops after a full
	// frame so surplus clocks cannot start a second access
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bit_cnt_q <= 5'h00;
			sh_q <= 16'h0000;
		end
		else if (ce)
		begin
			if (!frame_on)
				bit_cnt_q <= 5'h00;
			else if (rise && bit_cnt_q != 5'(ceq_pkg::FRAME_BITS))
			begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
				sh_q <= sh_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path: fetch at the eighth rise, drive from the eighth fall
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_q <= 1'b0;
			tx_q <= 8'h00;
			miso_q <= 1'b0;
			miso_oe_n_q <= 1'b1;
		end
		else if (ce)
		begin
			if (!frame_on)
			begin
				rd_q <= 1'b0;
				miso_q <= 1'b0;
				miso_oe_n_q <= 1'b1;
			end
			else if (hdr_done && rd_cmd)
			begin
				rd_q <= 1'b1;
				tx_q <= rd_word;
			end
			else if (fall && rd_q)
			begin
				miso_q <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
				miso_oe_n_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers, written at the sixteenth rise of a write
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mute_q <= ceq_pkg::MUTE_RST;
			bypass_q <= ceq_pkg::BYP_RST;
			sleep_q <= ceq_pkg::SLEEP_RST;
			ext_q <= ceq_pkg::EXT_RST;
			swing_q <= ceq_pkg::SWING_RST;
			cm_q <= ceq_pkg::CM_RST;
			coarse_q <= ceq_pkg::COARSE_RST;
			fine_q <= ceq_pkg::FINE_RST;
		end
		else if (ce && wr_en)
		begin
			if (wsel[0])
			begin
				mute_q <= wdat[ceq_pkg::GEN_MUTE_BIT];
				bypass_q <= wdat[ceq_pkg::GEN_BYP_BIT];
				// reserved code 11 is kept as written
				sleep_q <= wdat[ceq_pkg::GEN_SLEEP_LSB +: 2];
				ext_q <= wdat[ceq_pkg::GEN_EXT_BIT];
			end
			if (wsel[1])
			begin
				swing_q <= wdat[ceq_pkg::DRV_SWING_LSB +: 3];
				cm_q <= wdat[ceq_pkg::DRV_CM_LSB +: 3];
			end
			if (wsel[2])
			begin
				coarse_q <= wdat[ceq_pkg::LA_COARSE_BIT];
				fine_q <= wdat[ceq_pkg::LA_FINE_LSB +: 4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the flops
	assign spi.miso = miso_q;
	assign spi.miso_oe_n = miso_oe_n_q;
	assign mute = mute_q;
	assign bypass = bypass_q;
	assign sleep_mode = sleep_q;
	assign ext_reach = ext_q;
	assign output_differential_swing = swing_q;
	assign output_common_mode_level = cm_q;
	assign launch_coarse = coarse_q;
	assign launch_fine = fine_q;
endmodule : ceq_device

// [verilog/ceq_host.sv]
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps
// serial master with a reach sequencer, steered over ahb-lite
module ceq_host #(
	parameter int SCK_HALF = ceq_pkg::SCK_HALF_CYC,
	parameter int WAIT_CYC = ceq_pkg::EXT_WAIT_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	ceq_spi_if.host spi
);
	// the device needs half periods long enough for its own sampling
	if (SCK_HALF < 4) $error("SCK_HALF below 4 cycles");
	if (WAIT_CYC < 1) $error("WAIT_CYC below 1");

	logic miso_s;
	logic ap_q;
	logic [7:0] ap_addr_q;
	logic [31:0] hrdata_q;
	logic wr_cmd;
	logic wr_seq;
	logic [16:0] cmd_q;
	logic sw_pend_q;
	logic seq_en_q;
	logic [1:0] restore_q;
	logic [1:0] base_q;
	logic [4:0] thr_q;
	ceq_pkg::ceq_eng_t eng_q;
	logic [31:0] hc_q;
	logic [3:0] bi_q;
	logic [15:0] tx_q;
	logic [7:0] rx_q;
	logic rd_q;
	logic done_q;
	logic sck_q;
	logic ss_n_q;
	logic mosi_q;
	logic mosi_oe_n_q;
	logic half_end;
	ceq_pkg::ceq_seq_t seq_q;
	logic issued_q;
	logic tgt_q;
	logic ext_q;
	logic [31:0] wc_q;
	logic seq_rd;
	logic [6:0] seq_addr;
	logic [7:0] seq_data;
	logic seq_issue;
	logic start;
	logic [15:0] frame;
	logic [31:0] stat;

	ceq_sync #(
		.W(1),
		.INIT(1'b0)
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.ce(ce),
		.d(spi.miso),
		.q(miso_s)
	);

	////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, read data registered in address phase
	assign stat = {7'h0, rx_q[ceq_pkg::GEN_CD_BIT], 8'h0, rx_q, 6'h0,
		ext_q, eng_q != ceq_pkg::E_IDLE || sw_pend_q};
	assign wr_cmd = ap_q && ap_addr_q == ceq_pkg::HOST_CMD_OFS;
	assign wr_seq = ap_q && ap_addr_q == ceq_pkg::HOST_SEQ_OFS;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ap_q <= 1'b0;
			ap_addr_q <= 8'h00;
			hrdata_q <= 32'h0;
		end
		else if (ce)
		begin
			ap_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
			ap_addr_q <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite)
				hrdata_q <= haddr[7:0] == ceq_pkg::HOST_CMD_OFS ? 32'(cmd_q) :
					haddr[7:0] == ceq_pkg::HOST_STAT_OFS ? stat :
					haddr[7:0] == ceq_pkg::HOST_SEQ_OFS ?
					{19'h0, thr_q, 3'h0, base_q, restore_q, seq_en_q} : 32'h0;
		end
	end

	// software registers; a command while busy is dropped
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_q <= 17'h0;
			sw_pend_q <= 1'b0;
			seq_en_q <= 1'b0;
			restore_q <= ceq_pkg::RESTORE_RST;
			base_q <= 2'h0;
			thr_q <= ceq_pkg::THR_RST;
		end
		else if (ce)
		begin
			if (wr_cmd && !sw_pend_q && eng_q == ceq_pkg::E_IDLE)
			begin
				cmd_q <= hwdata[16:0];
				sw_pend_q <= seq_q == ceq_pkg::Q_OFF;
			end
			else if (start && !seq_issue)
				sw_pend_q <= 1'b0;
			if (wr_seq)
			begin
				seq_en_q <= hwdata[0];
				restore_q <= hwdata[2:1];
				base_q <= hwdata[4:3];
				thr_q <= hwdata[ceq_pkg::SEQ_THR_LSB +: 5];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer frames; reserved general bits always go out as zero
	assign seq_rd = seq_q == ceq_pkg::Q_RD_CD || seq_q == ceq_pkg::Q_RD_LEN
		|| seq_q == ceq_pkg::Q_EXT_POLL;
	assign seq_addr = seq_q == ceq_pkg::Q_RD_LEN ? ceq_pkg::REG_LEN :
		ceq_pkg::REG_GEN;
	assign seq_data = {1'b0, base_q,
		seq_q == ceq_pkg::Q_RESTORE ? restore_q : ceq_pkg::SLEEP_FORCE,
		seq_q == ceq_pkg::Q_SLEEP ? ext_q : tgt_q, 2'h0};
	assign seq_issue = seq_q != ceq_pkg::Q_OFF && seq_q != ceq_pkg::Q_WAIT
		&& !issued_q;
	assign start = eng_q == ceq_pkg::E_IDLE && !done_q &&
		(seq_issue || sw_pend_q);
	// write frames carry data, sequencer reads send zeros after the header
	assign frame = seq_issue ? {seq_rd, seq_addr, seq_rd ? 8'h00 : seq_data}
		: {cmd_q[ceq_pkg::CMD_RD_BIT], cmd_q[14:0]};

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			seq_q <= ceq_pkg::Q_OFF;
			issued_q <= 1'b0;
			tgt_q <= 1'b0;
			ext_q <= 1'b0;
			wc_q <= 32'h0;
		end
		else if (ce)
		begin
			if (start && seq_issue)
				issued_q <= 1'b1;
			else if (done_q)
				issued_q <= 1'b0;
			wc_q <= seq_q == ceq_pkg::Q_WAIT ? wc_q + 32'h1 : 32'h0;
			case (seq_q)
				ceq_pkg::Q_OFF:
					if (seq_en_q)
						seq_q <= ceq_pkg::Q_RD_CD;
				ceq_pkg::Q_RD_CD:
					if (done_q && issued_q)
						// without carrier the device stays normal
						seq_q <= !seq_en_q ? ceq_pkg::Q_OFF :
							rx_q[ceq_pkg::GEN_CD_BIT] ? ceq_pkg::Q_RD_LEN :
							ceq_pkg::Q_RD_CD;
				ceq_pkg::Q_RD_LEN:
					if (done_q && issued_q)
					begin
						if (rx_q[ceq_pkg::LEN_LSB +: 5] < thr_q)
						begin
							tgt_q <= 1'b1;
							seq_q <= ceq_pkg::Q_SLEEP;
						end
						else
							seq_q <= ceq_pkg::Q_RD_CD;
					end
				ceq_pkg::Q_SLEEP:
					if (done_q && issued_q)
						seq_q <= ceq_pkg::Q_SET_EXT;
				ceq_pkg::Q_SET_EXT:
					if (done_q && issued_q)
					begin
						ext_q <= tgt_q;
						seq_q <= ceq_pkg::Q_WAIT;
					end
				ceq_pkg::Q_WAIT:
					if (wc_q == 32'(WAIT_CYC - 1))
						seq_q <= ceq_pkg::Q_RESTORE;
				ceq_pkg::Q_RESTORE:
					if (done_q && issued_q)
						seq_q <= tgt_q ? ceq_pkg::Q_EXT_POLL : ceq_pkg::Q_RD_CD;
				ceq_pkg::Q_EXT_POLL:
					if (done_q && issued_q && !rx_q[ceq_pkg::GEN_CD_BIT])
					begin
						tgt_q <= 1'b0;
						seq_q <= ceq_pkg::Q_SLEEP;
					end
				default:
					seq_q <= ceq_pkg::Q_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial engine: clock idles low, data changes while clock is low,
	// miso is sampled late in the high phase to allow for sync delay
	assign half_end = hc_q == 32'(SCK_HALF - 1);

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			eng_q <= ceq_pkg::E_IDLE;
			hc_q <= 32'h0;
			bi_q <= 4'h0;
			tx_q <= 16'h0;
			rx_q <= 8'h00;
			rd_q <= 1'b0;
			done_q <= 1'b0;
			sck_q <= 1'b0;
			ss_n_q <= 1'b1;
			mosi_q <= 1'b0;
			mosi_oe_n_q <= 1'b1;
		end
		else if (ce)
		begin
			done_q <= 1'b0;
			hc_q <= half_end || eng_q == ceq_pkg::E_IDLE ? 32'h0 : hc_q + 32'h1;
			case (eng_q)
				ceq_pkg::E_IDLE:
					if (start)
					begin
						tx_q <= frame;
						rd_q <= frame[15];
						bi_q <= 4'h0;
						ss_n_q <= 1'b0;
						mosi_q <= frame[15];
						mosi_oe_n_q <= 1'b0;
						eng_q <= ceq_pkg::E_LOW;
					end
				ceq_pkg::E_LOW:
					if (half_end)
					begin
						sck_q <= 1'b1;
						eng_q <= ceq_pkg::E_HIGH;
					end
				ceq_pkg::E_HIGH:
				begin
					// one cycle after the eighth rise of a read
					if (hc_q == 32'h0 && rd_q && bi_q == 4'h7)
						mosi_oe_n_q <= 1'b1;
					if (half_end)
					begin
						rx_q <= {rx_q[6:0], miso_s};
						sck_q <= 1'b0;
						bi_q <= bi_q + 4'h1;
						tx_q <= {tx_q[14:0], 1'b0};
						mosi_q <= tx_q[14];
						eng_q <= bi_q == 4'hf ? ceq_pkg::E_END : ceq_pkg::E_LOW;
					end
				end
				ceq_pkg::E_END:
					if (half_end)
					begin
						ss_n_q <= 1'b1;
						mosi_oe_n_q <= 1'b1;
						eng_q <= ceq_pkg::E_GAP;
					end
				ceq_pkg::E_GAP:
					if (half_end)
					begin
						done_q <= 1'b1;
						eng_q <= ceq_pkg::E_IDLE;
					end
				default:
					eng_q <= ceq_pkg::E_IDLE;
			endcase
		end
	end

	assign spi.sck = sck_q;
	assign spi.ss_n = ss_n_q;
	assign spi.mosi = mosi_q;
	assign spi.mosi_oe_n = mosi_oe_n_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
endmodule : ceq_host

// [verification/ceq_chk.sv]
`timescale 1ns/10ps
module ceq_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic mosi_oe_n,
	input wire logic miso,
	input wire logic miso_oe_n
);
	logic sck_q;
	logic rd_q;
	logic [4:0] cnt_q;
	wire logic rise;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////
	// clock rises per frame; the first bit tells read from write
	assign rise = sck && !sck_q;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sck_q <= 1'b0;
			cnt_q <= 5'h0;
			rd_q <= 1'b0;
		end
		else
		begin
			sck_q <= sck;
			cnt_q <= ss_n ? 5'h0 : cnt_q + {4'h0, rise};
			rd_q <= (rise && cnt_q == 5'h0) ? mosi : rd_q;
		end
	end
	////////////////////////////////////////////////////////////////////////
	chk_sck_idle: assert property (ss_n && $past(ss_n) |-> !sck)
		else $error("serial clock moves outside a frame");
	chk_frame_len: assert property ($rose(ss_n) |-> cnt_q == 5'h10)
		else $error("frame closed without sixteen clocks");
	chk_mosi_stable: assert property (sck && !mosi_oe_n |-> $stable(mosi))
		else $error("data line moved while clock high");
	chk_sck_high: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
		else $error("clock high phase has wrong length");
	chk_wr_quiet: assert property (!rd_q && cnt_q != 5'h0 |-> miso_oe_n)
		else $error("device drives in a write frame");
	chk_miso_idle: assert property (ss_n [*6] |-> miso_oe_n)
		else $error("device drives while deselected");
	chk_rd_release: assert property (rd_q && cnt_q == 5'h8 && !sck |-> mosi_oe_n)
		else $error("master still drives after header");
	chk_rd_drive: assert property (rd_q && cnt_q == 5'h9 |-> !miso_oe_n)
		else $error("device not driving read data");
	chk_miso_edge: assert property (!miso_oe_n && $changed(miso) |-> !sck)
		else $error("read data changed while clock high");
	// main scenarios: both frame kinds completed, read data driven
	cover property (rd_q && cnt_q == 5'h10);
	cover property (!rd_q && cnt_q == 5'h10);
	cover property ($fell(miso_oe_n));
endmodule : ceq_chk

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
	logic core_clk, resetn, spi_en, carrier_detect, hsel, hwrite;
	logic mute, bypass, ext_reach, launch_coarse, hreadyout, hresp;
	logic [4:0] cable_length_code;
	logic [1:0] htrans, sleep_mode;
	logic [2:0] hsize, output_differential_swing, output_common_mode_level;
	logic [3:0] launch_fine;
	logic [7:0] g, o, l;
	logic [31:0] haddr, hwdata, hrdata, seen_v, rv;
	logic [31:0] exp_q[$];
	wire logic [15:0] dev_out;
	int fail_count, comparisons;
	event got_ev;
	ceq_spi_if spi_bus ();
	////////////////////////////////////////////////////////////////////////
	// the device's control outputs packed in register field order
	assign dev_out = {mute, bypass, sleep_mode, ext_reach,
		output_differential_swing, output_common_mode_level,
		launch_coarse, launch_fine};
	ceq_device ceq_device_inst (.core_clk(core_clk), .resetn(resetn),
		.ce(1'b1), .spi_en(spi_en), .carrier_detect(carrier_detect),
		.cable_length_code(cable_length_code), .spi(spi_bus), .mute(mute),
		.bypass(bypass), .sleep_mode(sleep_mode), .ext_reach(ext_reach),
		.output_differential_swing(output_differential_swing),
		.output_common_mode_level(output_common_mode_level),
		.launch_coarse(launch_coarse), .launch_fine(launch_fine));
	// short settle wait keeps the reach sequence inside the run budget
	ceq_host #(.WAIT_CYC(20)) ceq_host_inst (.core_clk(core_clk),
		.resetn(resetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .spi(spi_bus));
	ceq_chk ceq_chk_inst (.core_clk(core_clk), .resetn(resetn),
		.sck(spi_bus.sck), .ss_n(spi_bus.ss_n), .mosi(spi_bus.mosi),
		.mosi_oe_n(spi_bus.mosi_oe_n), .miso(spi_bus.miso),
		.miso_oe_n(spi_bus.miso_oe_n));
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic stop;
		fail_count++;
		$display("[FAIL] %0t wait ran out", $time);
		end_sim();
	endtask : stop
	task automatic note(input logic [31:0] v);
		exp_q.push_back(v);
	endtask : note
	// hand a result to the watcher; the pause keeps two results apart
	task automatic show(input logic [31:0] v);
		seen_v = v;
		-> got_ev;
		@(posedge core_clk);
	endtask : show
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
			stop();
	endtask : wait_rdy
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : ahb
	task automatic wait_idle;
		int n;
		n = 0;
		do
		begin
			ahb(1'b0, 8'h04, 32'h0, rv);
			n++;
		end
		while (rv[0] !== 1'b0 && n < 200);
		if (rv[0] !== 1'b0)
			stop();
	endtask : wait_idle
	task automatic spi_wr(input logic [6:0] a, input logic [7:0] d);
		ahb(1'b1, 8'h00, {16'h0, 1'b0, a, d}, rv);
		wait_idle();
	endtask : spi_wr
	task automatic spi_rd(input logic [6:0] a);
		ahb(1'b1, 8'h00, {15'h0, 1'b1, 1'b0, a, 8'h0}, rv);
		wait_idle();
		show({24'h0, rv[15:8]});
	endtask : spi_rd
	task automatic wait_dev(input logic [15:0] m, input logic [15:0] v);
		int n;
		n = 0;
		while ((dev_out & m) !== v && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		if ((dev_out & m) !== v)
			stop();
	endtask : wait_dev
	////////////////////////////////////////////////////////////////////////
	// watcher: every result is matched against the oldest expectation
	always @(got_ev)
		check(seen_v, exp_q.pop_front());
	initial
	begin
		resetn = 1'b0;
		spi_en = 1'b1;
		carrier_detect = 1'b0;
		cable_length_code = 5'h0;
		hsel = 1'b1;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		fail_count = 0;
		comparisons = 0;
		rv = $urandom(32'h4ee5f4c4);
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		note(32'h1320);
		show({16'h0, dev_out});
		$display("reset test done");
		// random field values; reserved bits stay zero
		for (int i = 0; i < 4; i++)
		begin
			g = 8'($urandom) & 8'h7c;
			o = 8'($urandom) & 8'hfc;
			l = 8'($urandom) & 8'hf8;
			spi_wr(7'h00, g);
			spi_wr(7'h01, o);
			spi_wr(7'h02, l);
			note({16'h0, g[6:2], o[7:2], l[7:3]});
			show({16'h0, dev_out});
			note({24'h0, 1'b0, g[6:2], 2'h0});
			spi_rd(7'h00);
			note({24'h0, o});
			spi_rd(7'h01);
			note({24'h0, l});
			spi_rd(7'h02);
		end
		$display("write and read test done");
		for (int j = 0; j < 3; j++)
		begin
			carrier_detect <= ~carrier_detect;
			cable_length_code <= 5'($urandom_range(25));
			repeat (8) @(posedge core_clk);
			note({24'h0, cable_length_code, 3'h0});
			spi_rd(7'h03);
			note({24'h0, carrier_detect, g[6:2], 2'h0});
			spi_rd(7'h00);
			note(32'h0);
			spi_rd(7'h05);
		end
		ahb(1'b0, 8'h0c, 32'h0, rv);
		note(32'h0);
		show(rv);
		$display("status test done");
		spi_en <= 1'b0;
		spi_wr(7'h01, ~o & 8'hfc);
		spi_en <= 1'b1;
		repeat (4) @(posedge core_clk);
		note({24'h0, o});
		spi_rd(7'h01);
		$display("pin mode test done");
		// reach sequence: enter on carrier and short cable, leave on loss
		spi_wr(7'h00, 8'h08);
		cable_length_code <= 5'h05;
		ahb(1'b1, 8'h08, 32'h1203, rv);
		wait_dev(16'h0800, 16'h0800);
		note(32'h2800);
		show({16'h0, dev_out & 16'h3800});
		wait_dev(16'h3800, 16'h1800);
		ahb(1'b0, 8'h04, 32'h0, rv);
		note(32'h1);
		show({31'h0, rv[1]});
		carrier_detect <= 1'b0;
		wait_dev(16'h0800, 16'h0);
		note(32'h2000);
		show({16'h0, dev_out & 16'h3800});
		wait_dev(16'h3800, 16'h1000);
		cable_length_code <= 5'h12;
		carrier_detect <= 1'b1;
		repeat (600) @(posedge core_clk);
		note(32'h0);
		show({16'h0, dev_out & 16'h0800});
		ahb(1'b1, 8'h08, 32'h0, rv);
		$display("reach test done");
		repeat (2) @(posedge core_clk);
		end_sim();
	end
endmodule : tb
